// ### rtl/adc_ctrl_defines.svh
// Register indices, field positions, reset values and timing counts
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define IDX_CTRL    8'h93
`define IDX_TIME    8'h94
`define IDX_RES_LO  8'h96
`define IDX_RES_HI  8'h97
`define IDX_IRQ_ST  8'h98
`define IDX_IRQ_MSK 8'h99

`define CTRL_DONE_BIT 6
`define RES_LO_W      2
`define IRQ_DONE_BIT  0
`define IRQ_HIT_BIT   1

`define RST_BYTE      8'h00
`define CONV_TADS     4'hC
`define SAMP_MIN      5'h02
`define SAMP_MAX      5'h0F

`define TAD_0 6'h02
`define TAD_1 6'h04
`define TAD_2 6'h06
`define TAD_3 6'h08
`define TAD_4 6'h0C
`define TAD_5 6'h10
`define TAD_6 6'h18
`define TAD_7 6'h20

`endif

// ### rtl/adc_ctrl_pkg.sv
// Types shared by the converter control logic
package adc_ctrl_pkg;

   typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT} phase_t;

   // Signals towards the analog core
   typedef struct packed {
      logic       power;
      logic       ref_sel;
      logic [2:0] channel;
      logic       sample;
      logic       convert;
   } core_ctrl_t;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       power;
      logic       done;
      logic       cmp_en;
      logic       ref_sel;
      logic [2:0] chan;
      logic       go;
   } ctrl_t;

   typedef struct packed {
      logic [2:0] div;
      logic       rsvd;
      logic [3:0] ts;
   } timing_t;

   typedef struct packed {
      ctrl_t      ctrl;
      timing_t    tim;
      logic [9:0] res;
      logic [1:0] ist;
      logic [1:0] imask;
      phase_t     phase;
      logic [5:0] tick;
      logic [3:0] cnt;
      logic [9:0] s1;
      logic [9:0] s2;
      logic [9:0] s3;
      logic [9:0] val;
      logic       waitreq;
      logic [7:0] rdata;
      logic       irq;
      core_ctrl_t core;
   } state_t;

endpackage

// ### rtl/adc_result_and_compare_control.sv
// Converter sequencing, result/threshold registers and Avalon-MM slave
`timescale 1ns/10ps
`include "adc_ctrl_defines.svh"

module adc_result_and_compare_control
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Analog core
   input  wire logic [9:0]  conv_data_i,
   output core_ctrl_t       core_o,
   // Interrupt
   output logic             irq_o
);

   state_t     s;
   state_t     n;
   logic [7:0] idx;
   logic       req;
   logic       commit;
   logic       take;
   logic [5:0] tad_len;
   logic [4:0] samp_len;
   logic       tick_end;
   logic       ev_done;
   logic       ev_hit;
   logic [7:0] wd;

   function automatic logic [5:0] tad_of(input logic [2:0] d);
      logic [5:0] r;
      r = `TAD_0;
      unique case (d)
         3'h0: r = `TAD_0;
         3'h1: r = `TAD_1;
         3'h2: r = `TAD_2;
         3'h3: r = `TAD_3;
         3'h4: r = `TAD_4;
         3'h5: r = `TAD_5;
         3'h6: r = `TAD_6;
         3'h7: r = `TAD_7;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] read_mux(input state_t st, input logic [7:0] i);
      logic [7:0] r;
      r = `RST_BYTE;
      if (i == `IDX_CTRL) begin
         r = st.ctrl;
      end else if (i == `IDX_TIME) begin
         r = st.tim;
      end else if (i == `IDX_RES_LO) begin
         r = {6'h00, st.res[`RES_LO_W-1:0]};
      end else if (i == `IDX_RES_HI) begin
         r = st.res[9:`RES_LO_W];
      end else if (i == `IDX_IRQ_ST) begin
         r = {6'h00, st.ist};
      end else if (i == `IDX_IRQ_MSK) begin
         r = {6'h00, st.imask};
      end
      return r;
   endfunction

   assign idx      = avs_address_i[9:2];
   assign req      = avs_read_i | avs_write_i;
   assign take     = req & s.waitreq;
   assign commit   = req & ~s.waitreq;
   assign wd       = avs_writedata_i[7:0];
   assign tad_len  = tad_of(s.tim.div);
   assign tick_end = (s.tick == tad_len - 6'h01);

   // Sample phase clamped to 2..15 periods
   always_comb begin
      samp_len = {1'b0, s.tim.ts} + 5'h01;
      if (samp_len < `SAMP_MIN) begin
         samp_len = `SAMP_MIN;
      end
      if (samp_len > `SAMP_MAX) begin
         samp_len = `SAMP_MAX;
      end
   end

   always_comb begin
      n       = s;
      ev_done = 1'b0;
      ev_hit  = 1'b0;

      // Three-stage input capture; accept once stages two and three agree
      n.s1 = conv_data_i;
      n.s2 = s.s1;
      n.s3 = s.s2;
      if (s.s2 == s.s3) begin
         n.val = s.s3;
      end

      // Conversion sequencer
      if (s.phase != PH_IDLE) begin
         n.tick = tick_end ? 6'h00 : s.tick + 6'h01;
      end
      unique case (s.phase)
         PH_IDLE: begin
            if (s.ctrl.go && s.ctrl.power) begin
               n.phase = PH_SAMPLE;
               n.tick  = 6'h00;
               n.cnt   = 4'h0;
            end
         end
         PH_SAMPLE: begin
            if (tick_end) begin
               if ({1'b0, s.cnt} == samp_len - 5'h01) begin
                  n.phase = PH_CONVERT;
                  n.cnt   = 4'h0;
               end else begin
                  n.cnt = s.cnt + 4'h1;
               end
            end
         end
         PH_CONVERT: begin
            if (tick_end) begin
               if (s.cnt == `CONV_TADS - 4'h1) begin
                  n.cnt = 4'h0;
                  if (s.ctrl.cmp_en) begin
                     // Threshold untouched, go kept, next conversion starts
                     n.phase = PH_SAMPLE;
                     if (s.val > s.res) begin
                        ev_hit = 1'b1;
                     end
                  end else begin
                     n.phase   = PH_IDLE;
                     n.res     = s.val;
                     n.ctrl.go = 1'b0;
                     ev_done   = 1'b1;
                  end
               end else begin
                  n.cnt = s.cnt + 4'h1;
               end
            end
         end
      endcase

      // Bus handshake: one wait cycle, then commit
      if (take) begin
         n.waitreq = 1'b0;
         n.rdata   = read_mux(s, idx);
      end
      if (commit) begin
         n.waitreq = 1'b1;
         if (avs_write_i && avs_byteenable_i[0]) begin
            if (idx == `IDX_CTRL) begin
               n.ctrl      = ctrl_t'(wd);
               n.ctrl.done = s.ctrl.done & wd[`CTRL_DONE_BIT];
            end else if (idx == `IDX_TIME) begin
               n.tim = {wd[7:5], 1'b0, wd[3:0]};
            end else if (idx == `IDX_RES_LO) begin
               n.res[`RES_LO_W-1:0] = wd[`RES_LO_W-1:0];
            end else if (idx == `IDX_RES_HI) begin
               n.res[9:`RES_LO_W] = wd;
            end else if (idx == `IDX_IRQ_MSK) begin
               n.imask = wd[1:0];
            end
         end
         if (avs_read_i && idx == `IDX_IRQ_ST) begin
            n.ist = s.ist & ~s.rdata[1:0];
         end
      end

      // Go cleared or power removed aborts on the commit edge, so core never runs unpowered
      if (!n.ctrl.go || !n.ctrl.power) begin
         n.phase = PH_IDLE;
         n.tick  = 6'h00;
         n.cnt   = 4'h0;
      end

      // Hardware set wins over any clear in the same cycle
      if (ev_done || ev_hit) begin
         n.ctrl.done = 1'b1;
      end
      if (ev_done) begin
         n.ist[`IRQ_DONE_BIT] = 1'b1;
      end
      if (ev_hit) begin
         n.ist[`IRQ_HIT_BIT] = 1'b1;
      end
      n.irq = |(n.ist & n.imask);

      // Core controls follow the committed registers
      n.core.power   = n.ctrl.power;
      n.core.ref_sel = n.ctrl.ref_sel;
      n.core.channel = n.ctrl.chan;
      n.core.sample  = (n.phase == PH_SAMPLE);
      n.core.convert = (n.phase == PH_CONVERT);
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s         <= '0;
         s.waitreq <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign avs_readdata_o    = {24'h000000, s.rdata};
   assign avs_waitrequest_o = s.waitreq;
   assign core_o            = s.core;
   assign irq_o             = s.irq;

endmodule

// ### tb/adc_core_model.sv
// Behavioural analog core: one fixed level per input channel
`timescale 1ns/10ps
module adc_core_model
   import adc_ctrl_pkg::*;
(
   // Control from the block
   input  wire core_ctrl_t core_i,
   // Converted level
   output logic [9:0]      conv_data_o
);
   // Channel N reads {N, 2B}; an unpowered core shows the inverse
   always_comb conv_data_o = core_i.power ? {core_i.channel, 7'h2B} : ~{core_i.channel, 7'h2B};
endmodule

// ### tb/adc_ctrl_monitor.sv
// Concurrent checks on the converter control ports
`timescale 1ns/10ps
module adc_ctrl_monitor
   import adc_ctrl_pkg::*;
(
   // Clock, reset and bus
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       avs_read_i,
   input wire logic       avs_write_i,
   input wire logic       avs_waitrequest_o,
   // Core and interrupt
   input wire core_ctrl_t core_o,
   input wire logic       irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered");
   bus_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   sample_min_a: assert property ($rose(core_o.sample) |=> core_o.sample[*3])
      else $error("sample phase too short");
   convert_min_a: assert property ($rose(core_o.convert) |=> core_o.convert[*8])
      else $error("conversion phase too short");
   phase_order_a: assert property ($rose(core_o.convert) |-> $past(core_o.sample))
      else $error("conversion without sample phase");
   power_need_a: assert property (core_o.sample || core_o.convert |-> core_o.power)
      else $error("core active while unpowered");
   irq_cause_a: assert property ($rose(irq_o) |-> $past(core_o.convert, 2))
      else $error("interrupt without finished conversion");
   chan_hold_a: assert property (core_o.convert |-> $stable(core_o.channel))
      else $error("channel changed during conversion");
endmodule

bind adc_result_and_compare_control adc_ctrl_monitor i_mon (.mclk_i, .rst_n_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .core_o, .irq_o);

// ### tb/adc_result_and_compare_control_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_result_and_compare_control_test;
   import adc_ctrl_pkg::*;
   typedef struct {logic [7:0] idx; logic [7:0] wr; logic [7:0] exp;} row_t;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [9:0]  avs_address_i = 10'h000;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0]  avs_byteenable_i = 4'hF;
   logic [2:0]  ch;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [9:0]  conv_data_i;
   core_ctrl_t  core_o;
   logic        irq_o;
   logic [7:0]  rd;
   int          err_count = 0;
   int          num_checks = 0;
   int          samp_cnt = 0;
   int          conv_cnt = 0;
   logic [9:0]  val = {3'h5, 7'h2B};
   row_t        rows [6] = '{'{8'h94, 8'hFF, 8'hEF}, '{8'h96, 8'hFF, 8'h03}, '{8'h97, 8'hA5, 8'hA5},
                             '{8'h99, 8'h03, 8'h03}, '{8'h98, 8'hFF, 8'h00}, '{8'h9A, 8'hFF, 8'h00}};
   row_t        tims [2] = '{'{8'h00, 8'h04, 8'h18}, '{8'h2F, 8'h3C, 8'h30}};

   adc_result_and_compare_control i_dut (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .conv_data_i, .core_o, .irq_o);
   adc_core_model i_core (.core_i(core_o), .conv_data_o(conv_data_i));

   always #50 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      samp_cnt += int'(core_o.sample);
      conv_cnt += int'(core_o.convert);
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge mclk_i);
      avs_address_i <= {idx, 2'b00};
      avs_writedata_i <= {24'h0, d};
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
      rd = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   task automatic waitbit(input int b, input logic v);
      do bus(1'b0, 8'h93, 8'h00); while (rd[b] !== v);
   endtask

   task automatic results;
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) rchk(rows[i].idx, 8'h00);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].idx, rows[i].wr);
         rchk(rows[i].idx, rows[i].exp);
      end
      $display("Register test done");
      foreach (tims[i]) begin
         bus(1'b1, 8'h94, tims[i].idx);
         samp_cnt = 0;
         conv_cnt = 0;
         bus(1'b1, 8'h93, 8'h8B);
         waitbit(0, 1'b0);
         chk(samp_cnt[7:0], tims[i].wr);
         chk(conv_cnt[7:0], tims[i].exp);
         rchk(8'h93, 8'hCA);
         rchk(8'h97, val[9:2]);
         rchk(8'h96, {6'h00, val[1:0]});
         chk({7'h00, irq_o}, 8'h01);
         rchk(8'h98, 8'h01);
         rchk(8'h98, 8'h00);
         chk({7'h00, irq_o}, 8'h00);
         bus(1'b1, 8'h93, 8'h8A);
         rchk(8'h93, 8'h8A);
      end
      $display("Conversion test done");
      bus(1'b1, 8'h94, 8'h00);
      bus(1'b1, 8'h97, 8'hAA);
      bus(1'b1, 8'h96, 8'h02);
      bus(1'b1, 8'h93, 8'h8B);
      wait (core_o.convert === 1'b1);
      repeat (10) @(posedge mclk_i);
      bus(1'b1, 8'h93, 8'h8A);
      repeat (30) @(posedge mclk_i);
      rchk(8'h93, 8'h8A);
      rchk(8'h97, 8'hAA);
      rchk(8'h96, 8'h02);
      rchk(8'h98, 8'h00);
      $display("Abort test done");
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, 8'h99, m == 1 ? 8'h00 : 8'h03);
         bus(1'b1, 8'h96, m == 2 ? 8'h03 : 8'h02);
         conv_cnt = 0;
         bus(1'b1, 8'h93, 8'hAB);
         if (m < 2) waitbit(6, 1'b1);
         wait (conv_cnt >= 72);
         rchk(8'h93, m < 2 ? 8'hEB : 8'hAB);
         chk({7'h00, irq_o}, m == 0 ? 8'h01 : 8'h00);
         rchk(8'h97, 8'hAA);
         rchk(8'h96, m == 2 ? 8'h03 : 8'h02);
         rchk(8'h98, m < 2 ? 8'h02 : 8'h00);
         bus(1'b1, 8'h93, 8'hAA);
         rchk(8'h93, 8'hAA);
      end
      $display("Compare test done");
      for (int c = 0; c < 8; c++) begin
         ch = c[2:0];
         bus(1'b1, 8'h93, {3'b100, ch[0], ch, 1'b1});
         waitbit(0, 1'b0);
         chk({3'h0, core_o.power, core_o.ref_sel, core_o.channel}, {3'h0, 1'b1, ch[0], ch});
         rchk(8'h97, {ch, 5'h0A});
      end
      rchk(8'h98, 8'h01);
      $display("Channel test done");
      samp_cnt = 0;
      bus(1'b1, 8'h93, 8'h0B);
      repeat (20) @(posedge mclk_i);
      chk(samp_cnt[7:0], 8'h00);
      rchk(8'h93, 8'h0B);
      bus(1'b1, 8'h93, 8'h8B);
      waitbit(0, 1'b0);
      rchk(8'h93, 8'hCA);
      avs_byteenable_i <= 4'hE;
      bus(1'b1, 8'h97, 8'h55);
      avs_byteenable_i <= 4'hF;
      rchk(8'h97, 8'hAA);
      $display("Power test done");
      bus(1'b1, 8'h93, 8'h8B);
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      chk({7'h00, avs_waitrequest_o}, 8'h01);
      chk({core_o, irq_o}, 8'h00);
      rchk(8'h93, 8'h00);
      foreach (rows[i]) rchk(rows[i].idx, 8'h00);
      $display("Reset test done");
      results;
   end

   initial begin
      #3000000;
      err_count++;
      results;
   end
endmodule
